// [logic/scg_top.sv]
// Purpose: System clock generator top
// Assumes: clk 100 MHz; derived clocks are registered levels except pll_ref_clk, a mux of sec_q[1] and clk_4mhz
// Notes:   Master 40 MHz is a 2/5 fractional enable
`timescale 1ns/1ps
module scg_top
   import scg_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic sync_reset,
   input  wire logic test_clk_sel,
   input  wire logic test_clk_tick,
   input  wire logic ref_freq_select,
   input  wire logic ext_phase4_clk,
   output logic      clk_20mhz,
   output logic      clk_8mhz,
   output logic      clk_4mhz,
   output logic      proc_clk_phase_a,
   output logic      proc_clk_phase_b,
   output logic      proc_clk_phase_delayed,
   output logic      clk_10mhz_test,
   output logic      clk_5mhz,
   output logic      pll_ref_clk,
   output logic      min_delay_1mhz_clk,
   output logic      phase_clk_2mhz,
   output logic      phase_clk_2mhz_n,
   output logic      phase_clk_2mhz_dly1,
   output logic      phase_clk_2mhz_dly2,
   output logic      phase4_resampled,
   output logic      ch1_output_sample_n,
   output logic      ch2_output_sample_n,
   output logic      well_reset_n,
   output logic      data_sync_n
);
   scg_tick_if tk ();

   logic [2:0]           acc_q;
   logic                 m40_tick;
   logic                 m40_int;
   logic                 fall_tick;
   logic [2:0]           d5_q;
   logic [SEC_WIDTH-1:0] sec_q;
   logic                 dly25_q;

   // ************************************************************
   // Master clock enable
   // ************************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_q <= DIV5_ZERO;
      end else if (acc_q + MASTER_ACC_STEP >= MASTER_ACC_MOD) begin
         acc_q <= acc_q + MASTER_ACC_STEP - MASTER_ACC_MOD;
      end else begin
         acc_q <= acc_q + MASTER_ACC_STEP;
      end
   end
   assign m40_int  = (acc_q + MASTER_ACC_STEP >= MASTER_ACC_MOD);
   assign m40_tick = test_clk_sel ? test_clk_tick : m40_int;

   // ************************************************************
   // 20 MHz, 8 MHz and 4 MHz
   // ************************************************************
   // Each master tick stands for one falling edge
   assign fall_tick = m40_tick;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clk_20mhz <= 1'b0;
      end else if (sync_reset) begin
         clk_20mhz <= 1'b0;
      end else if (fall_tick) begin
         clk_20mhz <= ~clk_20mhz;
      end
   end
   // Rising edge of 20 MHz is the tick for all 20 MHz logic
   assign tk.tick_20m = fall_tick && !clk_20mhz;
   assign tk.rst_sync = sync_reset;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         d5_q     <= DIV5_ZERO;
         clk_8mhz <= 1'b0;
      end else if (sync_reset) begin
         d5_q     <= DIV5_ZERO;
         clk_8mhz <= 1'b0;
      end else if (m40_tick) begin
         // High two master ticks, low three: one period per five ticks
         if (d5_q == DIV5_LAST) begin
            d5_q     <= DIV5_ZERO;
            clk_8mhz <= 1'b1;
         end else begin
            d5_q <= d5_q + 3'h1;
            if (d5_q == DIV5_HALF) begin
               clk_8mhz <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clk_4mhz <= 1'b0;
      end else if (sync_reset) begin
         clk_4mhz <= 1'b0;
      end else if (m40_tick && (d5_q == DIV5_LAST)) begin
         // Toggles on every rising edge of the 8 MHz clock
         clk_4mhz <= ~clk_4mhz;
      end
   end

   // ************************************************************
   // Secondary clocks
   // ************************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sec_q <= '0;
      end else if (sync_reset) begin
         sec_q <= '0;
      end else if (tk.tick_20m) begin
         sec_q <= sec_q + 3'h1;
      end
   end
   // Delayed copy: 3 cycles of 20 MHz = 150 ns behind
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dly25_q <= 1'b0;
      end else if (sync_reset) begin
         dly25_q <= 1'b0;
      end else if (tk.tick_20m && (sec_q == SEC_DLY_SET)) begin
         dly25_q <= 1'b1;
      end else if (tk.tick_20m && (sec_q == SEC_DLY_CLR)) begin
         dly25_q <= 1'b0;
      end
   end

   assign clk_10mhz_test         = sec_q[0];
   assign clk_5mhz               = sec_q[1];
   assign proc_clk_phase_a       = sec_q[2];
   assign proc_clk_phase_b       = sec_q[1];
   assign proc_clk_phase_delayed = dly25_q;
   assign pll_ref_clk = ref_freq_select ? sec_q[1] : clk_4mhz;

   // ************************************************************
   // Phase clocks and strobes
   // ************************************************************
   scg_phase_div u_phase (
      .clk                 (clk),
      .reset_n             (reset_n),
      .tk                  (tk),
      .min_delay_1mhz_clk  (min_delay_1mhz_clk),
      .phase_clk_2mhz      (phase_clk_2mhz),
      .phase_clk_2mhz_n    (phase_clk_2mhz_n),
      .phase_clk_2mhz_dly1 (phase_clk_2mhz_dly1),
      .phase_clk_2mhz_dly2 (phase_clk_2mhz_dly2)
   );

   scg_strobe_fsm u_strobe (
      .clk                 (clk),
      .reset_n             (reset_n),
      .tk                  (tk),
      .ext_phase4_clk      (ext_phase4_clk),
      .phase4_resampled    (phase4_resampled),
      .ch1_output_sample_n (ch1_output_sample_n),
      .ch2_output_sample_n (ch2_output_sample_n),
      .well_reset_n        (well_reset_n),
      .data_sync_n         (data_sync_n)
   );
endmodule

// [logic/scg_pkg.sv]
// Purpose: Constants for the system clock generator
// Assumes: One 100 MHz clock; all derived clocks are level outputs
package scg_pkg;
   // Master 40 MHz enable from 100 MHz: phase accumulator 2/5
   localparam logic [2:0] MASTER_ACC_STEP = 3'h2;
   localparam logic [2:0] MASTER_ACC_MOD  = 3'h5;
   localparam int         DIV5_COUNT      = 5;
   localparam logic [2:0] DIV5_LAST       = 3'h4;
   localparam logic [2:0] DIV5_ZERO       = 3'h0;
   localparam logic [2:0] DIV5_HALF       = 3'h1;
   localparam logic [3:0] PH_CNT_TOP      = 4'hC;
   localparam logic [3:0] PH_CNT_LOAD     = 4'h3;
   localparam logic [2:0] PH_CNT_DECODE   = 3'h7;
   localparam logic [3:0] IV_LOAD_IDLE    = 4'h5;
   localparam logic [3:0] IV_LOAD_OS      = 4'h4;
   localparam logic [3:0] IV_LOAD_RST     = 4'h5;
   localparam logic [3:0] IV_LOAD_END     = 4'h0;
   localparam int         IV_SHIFT_BIT    = 3;
   localparam int         SEC_WIDTH       = 3;
   localparam logic [2:0] SEC_DLY_SET     = 3'h6;
   localparam logic [2:0] SEC_DLY_CLR     = 3'h2;
   localparam int         DLY_STAGES      = 3;
   localparam int         DLY1_TAP        = 0;
   localparam int         DLY2_TAP        = 2;
   localparam int         STROBE_WIDTH    = 4;
   localparam logic [3:0] STROBE_IDLE     = 4'hF;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_COUNT = 4'h2,
      ST_SHIFT = 4'h4,
      ST_DONE  = 4'h8
   } scg_strobe_state_type;
endpackage

// [logic/scg_tick_if.sv]
// Purpose: Carries the 20 MHz tick between modules
// Assumes: Single clock domain
// Notes:   Tick is a one-cycle enable
`timescale 1ns/1ps
interface scg_tick_if;
   logic tick_20m;
   logic rst_sync;
   modport src (output tick_20m, output rst_sync);
   modport dst (input tick_20m, input rst_sync);
endinterface

// [logic/scg_phase_div.sv]
// Purpose: Divide-by-20 minimum-delay phase clock chain
// Assumes: Ticks from the 20 MHz enable
// Notes:   Delayed copies from a short shift register
`timescale 1ns/1ps
module scg_phase_div
   import scg_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset_n,
   scg_tick_if.dst   tk,
   output logic      min_delay_1mhz_clk,
   output logic      phase_clk_2mhz,
   output logic      phase_clk_2mhz_n,
   output logic      phase_clk_2mhz_dly1,
   output logic      phase_clk_2mhz_dly2
);
   logic [3:0]            cnt_q;
   logic [3:0]            cnt_d;
   logic [DLY_STAGES-1:0] dly_q;

   // Ten states 0011..1100; stray states above 1100 reload, those below 0011 count up
   always_comb begin
      if (cnt_q >= PH_CNT_TOP) begin
         cnt_d = PH_CNT_LOAD;
      end else begin
         cnt_d = cnt_q + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= PH_CNT_LOAD;
      end else if (tk.rst_sync) begin
         cnt_q <= PH_CNT_LOAD;
      end else if (tk.tick_20m) begin
         cnt_q <= cnt_d;
      end
   end

   // MSB of divide-by-ten counter, kept on the 20 MHz tick grid
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_clk_2mhz   <= 1'b0;
         phase_clk_2mhz_n <= 1'b1;
      end else if (tk.rst_sync) begin
         phase_clk_2mhz   <= 1'b0;
         phase_clk_2mhz_n <= 1'b1;
      end else if (tk.tick_20m) begin
         phase_clk_2mhz   <= cnt_d[3];
         phase_clk_2mhz_n <= ~cnt_d[3];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         min_delay_1mhz_clk <= 1'b0;
      end else if (tk.rst_sync) begin
         min_delay_1mhz_clk <= 1'b0;
      end else if (tk.tick_20m && (cnt_q[2:0] == PH_CNT_DECODE)) begin
         min_delay_1mhz_clk <= ~min_delay_1mhz_clk;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dly_q <= '0;
      end else if (tk.rst_sync) begin
         dly_q <= '0;
      end else if (tk.tick_20m) begin
         dly_q <= {dly_q[DLY_STAGES-2:0], cnt_q[3]};
      end
   end

   assign phase_clk_2mhz_dly1 = dly_q[DLY1_TAP];
   assign phase_clk_2mhz_dly2 = dly_q[DLY2_TAP];
endmodule

// [logic/scg_strobe_fsm.sv]
// Purpose: Output-sample and well-reset strobe sequencer
// Assumes: Phase-4 input synchronous to clk
// Notes:   Strobes active low
`timescale 1ns/1ps
module scg_strobe_fsm
   import scg_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset_n,
   scg_tick_if.dst   tk,
   input  wire logic ext_phase4_clk,
   output logic      phase4_resampled,
   output logic      ch1_output_sample_n,
   output logic      ch2_output_sample_n,
   output logic      well_reset_n,
   output logic      data_sync_n
);
   scg_strobe_state_type  state_q;
   logic [3:0]            iv_q;
   logic [STROBE_WIDTH-1:0] sr_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase4_resampled <= 1'b0;
      end else if (tk.rst_sync) begin
         phase4_resampled <= 1'b0;
      end else if (tk.tick_20m) begin
         phase4_resampled <= ext_phase4_clk;
      end
   end

   // Strobe register {sync, rst, os2, os1}; shifts toward higher index
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         iv_q    <= IV_LOAD_IDLE;
         sr_q    <= STROBE_IDLE;
      end else if (tk.rst_sync) begin
         state_q <= ST_IDLE;
         iv_q    <= IV_LOAD_IDLE;
         sr_q    <= STROBE_IDLE;
      end else if (tk.tick_20m) begin
         case (state_q)
            ST_IDLE: begin
               sr_q <= STROBE_IDLE;
               if (phase4_resampled) begin
                  // Count starts on the first tick with phase-4 high
                  iv_q    <= IV_LOAD_IDLE + 4'h1;
                  state_q <= ST_COUNT;
               end else begin
                  iv_q <= IV_LOAD_IDLE;
               end
            end
            ST_COUNT: begin
               if (iv_q[IV_SHIFT_BIT]) begin
                  // Shift in low on first step, high afterwards
                  sr_q <= {sr_q[STROBE_WIDTH-2:0], (sr_q == STROBE_IDLE) ? 1'b0 : 1'b1};
                  if (sr_q[1] == 1'b0) begin
                     iv_q <= IV_LOAD_RST;
                  end else if (sr_q[2] == 1'b0) begin
                     iv_q    <= IV_LOAD_END;
                     state_q <= ST_DONE;
                  end else begin
                     iv_q <= IV_LOAD_OS;
                  end
               end else begin
                  iv_q <= iv_q + 4'h1;
               end
            end
            ST_DONE: begin
               sr_q <= {sr_q[STROBE_WIDTH-2:0], 1'b1};
               if (!phase4_resampled) begin
                  state_q <= ST_IDLE;
               end else begin
                  state_q <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (!phase4_resampled) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   assign ch1_output_sample_n = sr_q[0];
   assign ch2_output_sample_n = sr_q[1];
   assign well_reset_n        = sr_q[2];
   assign data_sync_n         = sr_q[3];
endmodule

// [verification/scg_properties.sv]
// Purpose: Port checks for scg_top
// Assumes: One clk domain; figures in clk cycles
// Notes:   Test clock mode mutes rate checks
`timescale 1ns/1ps
module scg_properties (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sync_reset,
   input wire logic test_clk_sel,
   input wire logic test_clk_tick,
   input wire logic ref_freq_select,
   input wire logic ext_phase4_clk,
   input wire logic clk_20mhz,
   input wire logic clk_8mhz,
   input wire logic clk_4mhz,
   input wire logic clk_5mhz,
   input wire logic proc_clk_phase_a,
   input wire logic proc_clk_phase_delayed,
   input wire logic pll_ref_clk,
   input wire logic min_delay_1mhz_clk,
   input wire logic phase4_resampled,
   input wire logic ch1_output_sample_n,
   input wire logic ch2_output_sample_n,
   input wire logic well_reset_n
);
   // ****
   // Checks
   // ****
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n || sync_reset || test_clk_sel);
   sequence s_ch1_on;
      $fell(ch1_output_sample_n);
   endsequence
   sequence s_ch2_on;
      $rose(ch1_output_sample_n) && $fell(ch2_output_sample_n);
   endsequence
   property p_tick;
      $rose(clk_20mhz) |=> (!$rose(clk_20mhz)) [*4] ##1 $rose(clk_20mhz);
   endproperty
   a_tick: assert property (p_tick) else $error("20 MHz period wrong");
   property p_c8;
      $rose(clk_8mhz) |=> (!$rose(clk_8mhz)) [*8] ##[4:5] $rose(clk_8mhz);
   endproperty
   a_c8: assert property (p_c8) else $error("8 MHz period wrong");
   property p_ref;
      pll_ref_clk == (ref_freq_select ? clk_5mhz : clk_4mhz);
   endproperty
   a_ref: assert property (p_ref) else $error("Reference select wrong");
   property p_m1;
      $changed(min_delay_1mhz_clk) && !$past(sync_reset) |-> $rose(clk_20mhz);
   endproperty
   a_m1: assert property (p_m1) else $error("1 MHz edge off 20 MHz edge");
   property p_dly;
      $rose(proc_clk_phase_a) |-> ##15 $rose(proc_clk_phase_delayed);
   endproperty
   a_dly: assert property (p_dly) else $error("Delayed 2.5 MHz lag wrong");
   property p_p4;
      $rose(clk_20mhz) |-> phase4_resampled == $past(ext_phase4_clk);
   endproperty
   a_p4: assert property (p_p4) else $error("Phase-4 resample wrong");
   property p_os1;
      $rose(phase4_resampled) |-> ##20 s_ch1_on;
   endproperty
   a_os1: assert property (p_os1) else $error("Ch1 strobe late");
   property p_os2;
      s_ch1_on |-> ##25 s_ch2_on;
   endproperty
   a_os2: assert property (p_os2) else $error("Ch2 strobe late");
   property p_idle;
      $fell(phase4_resampled) |->
         ##6 (ch1_output_sample_n && ch2_output_sample_n && well_reset_n);
   endproperty
   a_idle: assert property (p_idle) else $error("Strobes not idle");
   property p_test;
      disable iff (!reset_n || sync_reset)
      test_clk_sel |=> $changed(clk_20mhz) == $past(test_clk_tick);
   endproperty
   a_test: assert property (p_test) else $error("Test clock not used");
   property p_rst;
      disable iff (!reset_n)
      sync_reset |=> !clk_20mhz && !min_delay_1mhz_clk && ch1_output_sample_n;
   endproperty
   a_rst: assert property (p_rst) else $error("Sync reset incomplete");
endmodule

bind scg_top scg_properties i_scg_properties (.clk, .reset_n, .sync_reset, .test_clk_sel,
   .test_clk_tick, .ref_freq_select, .ext_phase4_clk, .clk_20mhz, .clk_8mhz, .clk_4mhz,
   .clk_5mhz, .proc_clk_phase_a, .proc_clk_phase_delayed, .pll_ref_clk,
   .min_delay_1mhz_clk, .phase4_resampled, .ch1_output_sample_n, .ch2_output_sample_n,
   .well_reset_n);

// [verification/scg_phase_array_model.sv]
// Purpose: Phase clock array stand-in
// Assumes: Paced by the 1 MHz phase clock
// Notes:   Phase-4 held low while idle
`timescale 1ns/1ps
module scg_phase_array_model (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic run,
   input  wire logic min_delay_1mhz_clk,
   output logic      ext_phase4_clk
);
   logic prev_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_q         <= 1'b0;
         ext_phase4_clk <= 1'b0;
      end else begin
         prev_q <= min_delay_1mhz_clk;
         if (!run) begin
            ext_phase4_clk <= 1'b0;
         end else if (min_delay_1mhz_clk && !prev_q) begin
            ext_phase4_clk <= ~ext_phase4_clk;
         end
      end
   end
endmodule

// [verification/system_clock_generator_tb.sv]
// Purpose: Self-checking bench for scg_top
// Assumes: 100 MHz clk; inputs move 1 ns after edges
// Notes:   Spans counted in clk cycles
`timescale 1ns/1ps
module system_clock_generator_tb;
   logic        clk             = 1'b0;
   logic        reset_n         = 1'b0;
   logic        sync_reset      = 1'b0;
   logic        test_clk_sel    = 1'b0;
   logic        test_clk_tick   = 1'b0;
   logic        ref_freq_select = 1'b0;
   logic        run             = 1'b0;
   logic        ext_phase4_clk, clk_20mhz, clk_8mhz, clk_4mhz, proc_clk_phase_a;
   logic        proc_clk_phase_b, proc_clk_phase_delayed, clk_10mhz_test, clk_5mhz;
   logic        pll_ref_clk, min_delay_1mhz_clk, phase_clk_2mhz, phase_clk_2mhz_n;
   logic        phase_clk_2mhz_dly1, phase_clk_2mhz_dly2, phase4_resampled;
   logic        ch1_output_sample_n, ch2_output_sample_n, well_reset_n, data_sync_n;
   logic [20:0] mon;
   int          err_count       = 0;
   int          cmp_count       = 0;
   int          cyc_count       = 0;
   // ****
   // Harness
   // ****
   assign mon = {data_sync_n, proc_clk_phase_b, clk_8mhz,
      phase_clk_2mhz_n, ~phase4_resampled, well_reset_n, ~well_reset_n,
      ~ch2_output_sample_n, ~ch1_output_sample_n, phase4_resampled, pll_ref_clk,
      clk_20mhz, proc_clk_phase_delayed, phase_clk_2mhz_dly2, phase_clk_2mhz_dly1,
      clk_4mhz, phase_clk_2mhz, min_delay_1mhz_clk, proc_clk_phase_a, clk_5mhz,
      clk_10mhz_test};
   scg_top i_scg_top (.clk, .reset_n, .sync_reset, .test_clk_sel, .test_clk_tick,
      .ref_freq_select, .ext_phase4_clk, .clk_20mhz, .clk_8mhz, .clk_4mhz,
      .proc_clk_phase_a, .proc_clk_phase_b, .proc_clk_phase_delayed, .clk_10mhz_test,
      .clk_5mhz, .pll_ref_clk, .min_delay_1mhz_clk, .phase_clk_2mhz, .phase_clk_2mhz_n,
      .phase_clk_2mhz_dly1, .phase_clk_2mhz_dly2, .phase4_resampled,
      .ch1_output_sample_n, .ch2_output_sample_n, .well_reset_n, .data_sync_n);
   scg_phase_array_model i_scg_phase_array_model (.clk, .reset_n, .run,
      .min_delay_1mhz_clk, .ext_phase4_clk);
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc_count++;
      if (cyc_count == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic step;
      @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // Cycles from now until the next rise of mon[j]
   task automatic span(input int j, output logic [7:0] n);
      logic p;
      n = 8'h00;
      do begin
         p = mon[j];
         step();
         n = n + 8'h01;
      end while (!(mon[j] && !p) && n != 8'hFF);
   endtask
   task automatic lag(input int i, input int j, input logic [7:0] exp);
      logic [7:0] n;
      if (i >= 0) span(i, n);
      span(j, n);
      chk(n, exp);
   endtask
   task automatic chk_rst;
      chk({clk_20mhz, min_delay_1mhz_clk, phase_clk_2mhz_n, ch1_output_sample_n,
         ch2_output_sample_n, well_reset_n}, 8'h0F);
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_periods;
      logic [7:0] n;
      logic [7:0] m;
      lag(9, 9, 8'h05);
      lag(0, 0, 8'h0A);
      lag(1, 1, 8'h14);
      lag(2, 2, 8'h28);
      lag(5, 5, 8'h19);
      lag(4, 4, 8'h32);
      lag(4, 17, 8'h19);
      lag(3, 3, 8'h64);
      lag(3, 9, 8'h05);
      lag(4, 6, 8'h05);
      lag(4, 7, 8'h0F);
      lag(2, 8, 8'h0F);
      lag(19, 19, 8'h14);
      span(5, n);
      span(18, n);
      span(18, m);
      chk(n + m, 8'h19);
   endtask
   task automatic t_ref;
      ref_freq_select = 1'b1;
      lag(10, 10, 8'h14);
      ref_freq_select = 1'b0;
      lag(10, 10, 8'h19);
   endtask
   task automatic t_strobes;
      run = 1'b1;
      lag(11, 12, 8'h14);
      lag(-1, 13, 8'h19);
      lag(-1, 14, 8'h19);
      lag(-1, 15, 8'h14);
      lag(-1, 20, 8'h05);
      lag(16, 16, 8'h00 + 8'hC8);
      repeat (6) step();
      chk({ch1_output_sample_n, ch2_output_sample_n, well_reset_n}, 8'h07);
      run = 1'b0;
   endtask
   task automatic t_sync;
      logic [7:0] n;
      run = 1'b1;
      span(12, n);
      sync_reset = 1'b1;
      run = 1'b0;
      step();
      chk_rst();
      sync_reset = 1'b0;
   endtask
   task automatic t_test_clk;
      logic       p;
      logic [7:0] n;
      n = 8'h00;
      test_clk_sel = 1'b1;
      repeat (8) begin
         p = clk_20mhz;
         test_clk_tick = 1'b1;
         step();
         test_clk_tick = 1'b0;
         repeat (3) step();
         if (clk_20mhz !== p) n = n + 8'h01;
      end
      chk(n, 8'h08);
      test_clk_sel = 1'b0;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1;
      reset_n = 1'b1;
      chk_rst();
      t_periods();
      t_ref();
      t_strobes();
      t_sync();
      t_test_clk();
      end_of_test();
   end
endmodule
